//--- src/async_serial_channel.sv
// asynchronous serial channel: transmitter, receiver, modem lines, loopbacks
`timescale 1ns/1ns
module async_serial_channel (
  input wire logic CLK_I,                 // 10 MHz clock
  input wire logic RESET_I,               // synchronous reset, active high
  input wire logic BAUD_CLK_I,            // baud_input_clock, external source
  input wire logic [3:0] ADDR_I,          // register address
  input wire logic [7:0] WDATA_I,         // write data
  input wire logic WR_I,                  // write strobe
  input wire logic RD_I,                  // read strobe
  output logic [7:0] RDATA_O,             // read data, one cycle after strobe
  input wire logic SERIAL_IN_I,           // serial_in pin
  output logic SERIAL_OUT_O,              // serial_out pin
  input wire logic CLEAR_TO_SEND_N_I,     // modem input
  input wire logic SET_READY_N_I,         // modem input
  input wire logic CARRIER_DETECT_N_I,    // modem input
  input wire logic RING_INDICATE_N_I,     // modem input
  output logic REQUEST_TO_SEND_N_O,       // modem output
  output logic TERMINAL_READY_N_O,        // modem output
  output logic CHANNEL_INTERRUPT_O,       // channel_interrupt
  output logic RX_FULL_DMA_REQUEST_O,     // rx_full_dma_request
  output logic TX_EMPTY_DMA_REQUEST_O     // transmit buffer empty request
);
  typedef enum logic [2:0] {IDLE, START, DATA, PAR, STOP} phase_t;

  // =======================================================
  // registers written by software
  logic [7:0] line_ctrl_r, modem_ctrl_r, irq_en_r, scratch_r, config_r;
  logic [15:0] divisor_r;
  logic [7:0] tx_buf_r;
  logic wr_data, rd_data, rd_lsr, rd_msr;
  assign wr_data = WR_I && ADDR_I == serial_channel_pkg::REG_DATA;
  assign rd_data = RD_I && ADDR_I == serial_channel_pkg::REG_DATA;
  assign rd_lsr = RD_I && ADDR_I == serial_channel_pkg::REG_LINE_STATUS;
  assign rd_msr = RD_I && ADDR_I == serial_channel_pkg::REG_MODEM_STATUS;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      line_ctrl_r <= serial_channel_pkg::LINE_CTRL_RST;
      modem_ctrl_r <= 8'h00;
      irq_en_r <= 8'h00;
      scratch_r <= 8'h00;
      config_r <= 8'h00;
      divisor_r <= serial_channel_pkg::DIVISOR_RST;
      tx_buf_r <= 8'h00;
    end else if (WR_I) begin
      case (ADDR_I)
        serial_channel_pkg::REG_DATA: tx_buf_r <= WDATA_I;
        serial_channel_pkg::REG_IRQ_ENABLE: irq_en_r <= {4'h0, WDATA_I[3:0]};
        serial_channel_pkg::REG_LINE_CTRL: line_ctrl_r <= {1'b0, WDATA_I[6:0]};
        serial_channel_pkg::REG_MODEM_CTRL: modem_ctrl_r <= {3'h0, WDATA_I[4:0]};
        serial_channel_pkg::REG_SCRATCH: scratch_r <= WDATA_I;
        // a zero divisor is not legal; a zero low-byte write with a zero high byte loads one
        serial_channel_pkg::REG_DIV_LOW: divisor_r[7:0] <= (WDATA_I == 8'h00 && divisor_r[15:8] == 8'h00) ?
                                                           8'h01 : WDATA_I;
        serial_channel_pkg::REG_DIV_HIGH: divisor_r[15:8] <= WDATA_I;
        serial_channel_pkg::REG_CONFIG: config_r <= {7'h00, WDATA_I[0]};
        default: ;
      endcase
    end
  end

  logic diag, modem_loop, par_en, par_even, par_sticky, stop2;
  logic [1:0] len_sel;
  logic [3:0] data_bits;
  assign diag = modem_ctrl_r[serial_channel_pkg::MC_DIAG];
  assign modem_loop = config_r[serial_channel_pkg::CF_MODEM_LOOP];
  assign par_en = line_ctrl_r[serial_channel_pkg::LC_PARITY_ENABLE];
  assign par_even = line_ctrl_r[serial_channel_pkg::LC_EVEN_PARITY_SELECT];
  assign par_sticky = line_ctrl_r[serial_channel_pkg::LC_STICKY_PARITY];
  assign stop2 = line_ctrl_r[serial_channel_pkg::LC_STOP2];
  assign len_sel = line_ctrl_r[serial_channel_pkg::LC_LEN_LSB +: 2];
  assign data_bits = 4'h5 + {2'b00, len_sel};

  // =======================================================
  // input synchronisers, one generate loop over all pins
  logic [5:0] pin_raw, pin_s1, pin_s2;
  assign pin_raw = {BAUD_CLK_I, SERIAL_IN_I, RING_INDICATE_N_I, CARRIER_DETECT_N_I,
                    SET_READY_N_I, CLEAR_TO_SEND_N_I};
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
          pin_s1[gi] <= 1'b1;
          pin_s2[gi] <= 1'b1;
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
        end
      end
    end
  endgenerate

  // =======================================================
  // baud generator: divides the external clock's rising edges
  logic baud_d_r, baud_edge, tick;
  logic [15:0] div_cnt_r;
  always_ff @(posedge CLK_I) begin
    // reset at the synchroniser's idle level, so no false edge follows reset
    if (RESET_I) baud_d_r <= 1'b1;
    else baud_d_r <= pin_s2[5];
  end
  assign baud_edge = pin_s2[5] && !baud_d_r;
  always_ff @(posedge CLK_I) begin
    if (RESET_I) div_cnt_r <= 16'h0001;
    else if (baud_edge) div_cnt_r <= (div_cnt_r >= divisor_r) ? 16'h0001 : div_cnt_r + 16'h0001;
  end
  assign tick = baud_edge && div_cnt_r >= divisor_r;

  // =======================================================
  // transmitter
  phase_t tx_ph_r;
  logic [7:0] tx_sh_r;
  logic [3:0] tx_sub_r, tx_bit_r;
  logic tx_par_r, tx_bit_out, tbe_r, te_r, tx_line;
  logic par_calc_tx;
  assign par_calc_tx = par_sticky ? !par_even : (par_even ? tx_par_r : !tx_par_r);

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      tx_ph_r <= IDLE;
      tx_sh_r <= 8'h00;
      tx_sub_r <= 4'h0;
      tx_bit_r <= 4'h0;
      tx_par_r <= 1'b0;
    end else if (tx_ph_r == IDLE) begin
      if (!tbe_r) begin
        tx_ph_r <= START;
        tx_sh_r <= tx_buf_r;
        tx_sub_r <= 4'h0;
        tx_par_r <= 1'b0;
      end
    end else if (tick) begin
      tx_sub_r <= tx_sub_r + 4'h1;
      if (tx_sub_r == serial_channel_pkg::OVERSAMPLE) begin
        case (tx_ph_r)
          START: begin
            tx_ph_r <= DATA;
            tx_bit_r <= 4'h0;
          end
          DATA: begin
            tx_par_r <= tx_par_r ^ tx_sh_r[0];
            tx_sh_r <= {1'b0, tx_sh_r[7:1]};
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_bit_r == data_bits - 4'h1) begin
              tx_ph_r <= par_en ? PAR : STOP;
              tx_bit_r <= 4'h0;
            end
          end
          PAR: tx_ph_r <= STOP;
          STOP: begin
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_bit_r == {3'h0, stop2}) tx_ph_r <= IDLE;
          end
          default: tx_ph_r <= IDLE;
        endcase
      end
    end
  end

  always_comb begin
    case (tx_ph_r)
      START: tx_bit_out = 1'b0;
      DATA: tx_bit_out = tx_sh_r[0];
      PAR: tx_bit_out = par_calc_tx;
      default: tx_bit_out = 1'b1;
    endcase
  end
  // break holds spacing for as long as the control bit stays set
  assign tx_line = tx_bit_out && !line_ctrl_r[serial_channel_pkg::LC_BREAK];

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      tbe_r <= 1'b1;
      te_r <= 1'b1;
    // a write in the load cycle keeps the buffer marked full
    end else if (wr_data) begin
      tbe_r <= 1'b0;
      te_r <= 1'b0;
    end else begin
      if (tx_ph_r == IDLE && !tbe_r) tbe_r <= 1'b1;
      if (tx_ph_r == STOP && tick && tx_sub_r == serial_channel_pkg::OVERSAMPLE &&
          tx_bit_r == {3'h0, stop2} && tbe_r) te_r <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) SERIAL_OUT_O <= 1'b1;
    else SERIAL_OUT_O <= diag ? 1'b1 : tx_line;
  end

  // =======================================================
  // receiver
  phase_t rx_ph_r;
  logic rx_line;
  logic [7:0] rx_sh_r, rx_buf_r;
  logic [3:0] rx_sub_r, rx_bit_r;
  logic rx_par_r, rx_pe_r, rx_zero_r;
  logic rbf_r, pe_r, fe_r, oe_r, bi_r, rx_done, sample;
  logic [7:0] rx_aligned;
  // a low stop bit leaves the line low, so a new start is taken at once
  assign rx_line = diag ? tx_line : pin_s2[4];
  assign sample = tick && rx_sub_r == serial_channel_pkg::MID_BIT;
  assign rx_aligned = rx_sh_r >> (4'h8 - data_bits);

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rx_ph_r <= IDLE;
      rx_sh_r <= 8'h00;
      rx_sub_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_par_r <= 1'b0;
      rx_pe_r <= 1'b0;
      rx_zero_r <= 1'b1;
    end else if (rx_ph_r == IDLE) begin
      if (tick && !rx_line) begin
        rx_ph_r <= START;
        rx_sub_r <= 4'h1;
      end
    end else if (tick) begin
      rx_sub_r <= rx_sub_r + 4'h1;
      if (sample) begin
        case (rx_ph_r)
          START: begin
            rx_ph_r <= rx_line ? IDLE : DATA;
            rx_bit_r <= 4'h0;
            rx_par_r <= 1'b0;
            rx_zero_r <= 1'b1;
          end
          DATA: begin
            rx_sh_r <= {rx_line, rx_sh_r[7:1]};
            rx_par_r <= rx_par_r ^ rx_line;
            rx_zero_r <= rx_zero_r && !rx_line;
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == data_bits - 4'h1) rx_ph_r <= par_en ? PAR : STOP;
          end
          PAR: begin
            rx_pe_r <= par_sticky ? (rx_line != !par_even)
                                  : ((rx_par_r ^ rx_line) != !par_even);
            rx_zero_r <= rx_zero_r && !rx_line;
            rx_ph_r <= STOP;
          end
          STOP: rx_ph_r <= IDLE;
          default: rx_ph_r <= IDLE;
        endcase
      end
    end
  end
  // one stop bit is checked; a low stop after all-low bits is a break
  // a completing character wins over a buffer read in the same cycle
  assign rx_done = sample && rx_ph_r == STOP;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rbf_r <= 1'b0;
      pe_r <= 1'b0;
      fe_r <= 1'b0;
      bi_r <= 1'b0;
      oe_r <= 1'b0;
      rx_buf_r <= 8'h00;
    end else begin
      if (rx_done) begin
        pe_r <= par_en && rx_pe_r;
        fe_r <= !rx_line;
        bi_r <= !rx_line && rx_zero_r;
        rx_buf_r <= rx_aligned;
        rbf_r <= 1'b1;
      end else if (rd_data) begin
        rbf_r <= 1'b0;
        pe_r <= 1'b0;
        fe_r <= 1'b0;
        bi_r <= 1'b0;
      end
      if (rx_done && rbf_r) oe_r <= 1'b1;
      else if (rd_lsr) oe_r <= 1'b0;
    end
  end

  // =======================================================
  // modem lines
  // in diagnostic mode ring follows out2 and carrier follows out1
  logic [3:0] modem_in, modem_d_r, modem_chg_r;
  always_comb begin
    if (diag) begin
      modem_in = {!modem_ctrl_r[serial_channel_pkg::MC_OUT2], !modem_ctrl_r[serial_channel_pkg::MC_OUT1],
                  !modem_ctrl_r[serial_channel_pkg::MC_TERMINAL_READY],
                  !modem_ctrl_r[serial_channel_pkg::MC_REQUEST_TO_SEND]};
    end else if (modem_loop) begin
      modem_in = {1'b1, !modem_ctrl_r[serial_channel_pkg::MC_TERMINAL_READY],
                  !modem_ctrl_r[serial_channel_pkg::MC_TERMINAL_READY],
                  !modem_ctrl_r[serial_channel_pkg::MC_REQUEST_TO_SEND]};
    end else begin
      modem_in = pin_s2[3:0];
    end
  end
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      modem_d_r <= 4'hF;
      modem_chg_r <= 4'h0;
    end else begin
      modem_d_r <= modem_in;
      modem_chg_r <= (modem_in ^ modem_d_r) | (rd_msr ? 4'h0 : modem_chg_r);
    end
  end
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      REQUEST_TO_SEND_N_O <= 1'b1;
      TERMINAL_READY_N_O <= 1'b1;
    end else begin
      REQUEST_TO_SEND_N_O <= diag || !modem_ctrl_r[serial_channel_pkg::MC_REQUEST_TO_SEND];
      TERMINAL_READY_N_O <= diag || !modem_ctrl_r[serial_channel_pkg::MC_TERMINAL_READY];
    end
  end

  // =======================================================
  // requests and read port
  logic any_err;
  assign any_err = pe_r || fe_r || oe_r || bi_r;
  assign RX_FULL_DMA_REQUEST_O = rbf_r && !any_err;
  assign TX_EMPTY_DMA_REQUEST_O = tbe_r;
  assign CHANNEL_INTERRUPT_O = (irq_en_r[serial_channel_pkg::IE_RX_FULL] && rbf_r) ||
                               (irq_en_r[serial_channel_pkg::IE_TX_EMPTY] && tbe_r) ||
                               (irq_en_r[serial_channel_pkg::IE_LINE] && any_err) ||
                               (irq_en_r[serial_channel_pkg::IE_MODEM] && |modem_chg_r);

  always_ff @(posedge CLK_I) begin
    // read data stand for one cycle only, zero otherwise
    if (RESET_I) RDATA_O <= 8'h00;
    else if (RD_I) begin
      case (ADDR_I)
        serial_channel_pkg::REG_DATA: RDATA_O <= rx_buf_r;
        serial_channel_pkg::REG_IRQ_ENABLE: RDATA_O <= irq_en_r;
        serial_channel_pkg::REG_LINE_CTRL: RDATA_O <= line_ctrl_r;
        serial_channel_pkg::REG_MODEM_CTRL: RDATA_O <= modem_ctrl_r;
        serial_channel_pkg::REG_LINE_STATUS: RDATA_O <= {1'b0, te_r, tbe_r, bi_r, fe_r, pe_r, oe_r, rbf_r};
        serial_channel_pkg::REG_MODEM_STATUS: RDATA_O <= {~modem_d_r, modem_chg_r};
        serial_channel_pkg::REG_SCRATCH: RDATA_O <= scratch_r;
        serial_channel_pkg::REG_DIV_LOW: RDATA_O <= divisor_r[7:0];
        serial_channel_pkg::REG_DIV_HIGH: RDATA_O <= divisor_r[15:8];
        serial_channel_pkg::REG_CONFIG: RDATA_O <= config_r;
        default: RDATA_O <= 8'h00;
      endcase
    end else RDATA_O <= 8'h00;
  end
endmodule : async_serial_channel

//--- src/serial_channel_pkg.sv
// constants for the asynchronous serial channel
package serial_channel_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] REG_DATA = 4'h0;       // write: tx buffer, read: rx buffer
  localparam logic [3:0] REG_IRQ_ENABLE = 4'h1;
  localparam logic [3:0] REG_LINE_CTRL = 4'h3;
  localparam logic [3:0] REG_MODEM_CTRL = 4'h4;
  localparam logic [3:0] REG_LINE_STATUS = 4'h5;
  localparam logic [3:0] REG_MODEM_STATUS = 4'h6;
  localparam logic [3:0] REG_SCRATCH = 4'h7;
  localparam logic [3:0] REG_DIV_LOW = 4'h8;
  localparam logic [3:0] REG_DIV_HIGH = 4'h9;
  localparam logic [3:0] REG_CONFIG = 4'hA;
  // line control fields
  localparam int LC_LEN_LSB = 0;
  localparam int LC_STOP2 = 2;
  localparam int LC_PARITY_ENABLE = 3;
  localparam int LC_EVEN_PARITY_SELECT = 4;
  localparam int LC_STICKY_PARITY = 5;
  localparam int LC_BREAK = 6;
  // modem control fields
  localparam int MC_TERMINAL_READY = 0;
  localparam int MC_REQUEST_TO_SEND = 1;
  localparam int MC_OUT1 = 2;
  localparam int MC_OUT2 = 3;
  localparam int MC_DIAG = 4;
  // config fields
  localparam int CF_MODEM_LOOP = 0;
  // interrupt enable fields
  localparam int IE_RX_FULL = 0;
  localparam int IE_TX_EMPTY = 1;
  localparam int IE_LINE = 2;
  localparam int IE_MODEM = 3;
  // reset values
  localparam logic [7:0] LINE_CTRL_RST = 8'h03;
  localparam logic [15:0] DIVISOR_RST = 16'h0001;
  localparam logic [3:0] OVERSAMPLE = 4'hF;     // sixteen ticks per bit, minus one
  localparam logic [3:0] MID_BIT = 4'h7;
endpackage : serial_channel_pkg

//--- sim/async_serial_channel_props.sv
// port assertions for the serial channel
`timescale 1ns/1ns
module async_serial_channel_props (
  input wire logic CLK_I, // clock
  input wire logic RESET_I, // reset
  input wire logic [3:0] ADDR_I, // address
  input wire logic [7:0] WDATA_I, // write data
  input wire logic WR_I, // write strobe
  input wire logic RD_I, // read strobe
  input wire logic [7:0] RDATA_O, // read data
  input wire logic SERIAL_OUT_O, // serial out
  input wire logic REQUEST_TO_SEND_N_O, // modem out
  input wire logic TERMINAL_READY_N_O, // modem out
  input wire logic CHANNEL_INTERRUPT_O, // interrupt
  input wire logic RX_FULL_DMA_REQUEST_O, // rx dma
  input wire logic TX_EMPTY_DMA_REQUEST_O // tx dma
);
  // ==========
  // mirrors of control bits, and one-cycle delayed copies
  logic diag_r, diag_d, brk_r, brk_d, ien_r, stat_r, dma_r;
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      diag_r <= 1'b0;
      diag_d <= 1'b0;
      brk_r <= 1'b0;
      brk_d <= 1'b0;
      ien_r <= 1'b0;
      stat_r <= 1'b0;
      dma_r <= 1'b0;
    end else begin
      if (WR_I && ADDR_I == serial_channel_pkg::REG_MODEM_CTRL) begin
        diag_r <= WDATA_I[serial_channel_pkg::MC_DIAG];
      end
      if (WR_I && ADDR_I == serial_channel_pkg::REG_LINE_CTRL) begin
        brk_r <= WDATA_I[serial_channel_pkg::LC_BREAK];
      end
      if (WR_I && ADDR_I == serial_channel_pkg::REG_IRQ_ENABLE) begin
        ien_r <= WDATA_I[serial_channel_pkg::IE_RX_FULL];
      end
      diag_d <= diag_r;
      brk_d <= brk_r;
      stat_r <= RD_I && ADDR_I == serial_channel_pkg::REG_LINE_STATUS;
      dma_r <= RX_FULL_DMA_REQUEST_O;
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // ==========
  // assertions
  reset_state_a: assert property ($past(RESET_I) |-> TX_EMPTY_DMA_REQUEST_O && !RX_FULL_DMA_REQUEST_O)
    else $error("empty flag or rx dma wrong after reset");
  rd_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data not zero outside read cycle");
  dma_block_a: assert property (stat_r |-> dma_r == (RDATA_O[0] && RDATA_O[4:1] == 4'h0))
    else $error("rx dma request disagrees with status");
  tx_write_a: assert property (WR_I && ADDR_I == serial_channel_pkg::REG_DATA |-> ##1 !TX_EMPTY_DMA_REQUEST_O)
    else $error("buffer write did not clear empty");
  break_hold_a: assert property (brk_r && brk_d && !diag_r && !diag_d |-> !SERIAL_OUT_O)
    else $error("break not holding output low");
  diag_out_a: assert property (diag_r && diag_d |-> SERIAL_OUT_O)
    else $error("output not high in diagnostic mode");
  diag_modem_a: assert property (diag_r && diag_d |-> REQUEST_TO_SEND_N_O && TERMINAL_READY_N_O)
    else $error("modem outputs active in diagnostic mode");
  rx_irq_a: assert property (ien_r && RX_FULL_DMA_REQUEST_O |-> CHANNEL_INTERRUPT_O)
    else $error("enabled rx full not on interrupt");
endmodule : async_serial_channel_props
bind async_serial_channel async_serial_channel_props i_props (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .SERIAL_OUT_O(SERIAL_OUT_O), .REQUEST_TO_SEND_N_O(REQUEST_TO_SEND_N_O),
  .TERMINAL_READY_N_O(TERMINAL_READY_N_O), .CHANNEL_INTERRUPT_O(CHANNEL_INTERRUPT_O),
  .RX_FULL_DMA_REQUEST_O(RX_FULL_DMA_REQUEST_O), .TX_EMPTY_DMA_REQUEST_O(TX_EMPTY_DMA_REQUEST_O)
);

//--- sim/serial_peer.sv
// far-side serial device: frame sender, frame catcher, modem lines
`timescale 1ns/1ns
module serial_peer #(
  parameter int BIT_NS = 8032
) (
  input wire logic serial_out_i, // device serial output
  output logic serial_in_o, // device serial input
  output logic [3:0] modem_n_o // ri, dcd, dsr, cts, active low
);
  logic [3:0] modem_n = 4'hF;
  int rx_n = 9;
  logic [31:0] got[$];
  assign modem_n_o = modem_n;
  initial serial_in_o = 1'b1;
  // ==========
  // start bit, then n bits least significant first, then mark
  task automatic send(input logic [31:0] bits, input int n);
    serial_in_o = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < n; i++) begin
      serial_in_o = bits[i];
      #(BIT_NS);
    end
    serial_in_o = 1'b1;
  endtask : send
  // ==========
  // catcher samples mid-bit after each start edge
  initial begin : catcher
    logic [31:0] fr;
    forever begin
      @(negedge serial_out_i);
      #(BIT_NS / 2);
      fr = 32'h0;
      for (int i = 0; i < rx_n; i++) begin
        #(BIT_NS);
        fr[i] = serial_out_i;
      end
      got.push_back(fr);
      wait (serial_out_i === 1'b1);
    end
  end
endmodule : serial_peer

//--- sim/testbench.sv
// self-checking bench for the serial channel
`timescale 1ns/1ns
module testbench;
  localparam logic [3:0] data_adr = serial_channel_pkg::REG_DATA;
  localparam logic [3:0] lctl_adr = serial_channel_pkg::REG_LINE_CTRL;
  localparam logic [3:0] mctl_adr = serial_channel_pkg::REG_MODEM_CTRL;
  localparam logic [3:0] stat_adr = serial_channel_pkg::REG_LINE_STATUS;
  localparam logic [3:0] msta_adr = serial_channel_pkg::REG_MODEM_STATUS;
  logic clk = 1'b0, rst = 1'b1, bclk = 1'b0, wr = 1'b0, rd = 1'b0, pend = 1'b0, sin, sout;
  logic [3:0] addr = 4'h0, mdm_n;
  logic [7:0] wdata = 8'h00, rdata, d, lc;
  logic [7:0] lcs[5] = '{8'h2B, 8'h3B, 8'h04, 8'h1A, 8'h0B};
  logic [7:0] exp_q[$], msk_q[$];
  logic [31:0] f, fexp_q[$];
  string nm_q[$];
  int n_fail = 0, checked = 0, pos;
  initial forever #50 clk = ~clk;
  initial forever #251 bclk = ~bclk;
  async_serial_channel i_dut (
    .CLK_I(clk), .RESET_I(rst), .BAUD_CLK_I(bclk), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .SERIAL_IN_I(sin), .SERIAL_OUT_O(sout), .CLEAR_TO_SEND_N_I(mdm_n[0]),
    .SET_READY_N_I(mdm_n[1]), .CARRIER_DETECT_N_I(mdm_n[2]), .RING_INDICATE_N_I(mdm_n[3]),
    .REQUEST_TO_SEND_N_O(), .TERMINAL_READY_N_O(), .CHANNEL_INTERRUPT_O(), .RX_FULL_DMA_REQUEST_O(),
    .TX_EMPTY_DMA_REQUEST_O()
  );
  serial_peer #(.BIT_NS(8032)) i_peer (.serial_out_i(sout), .serial_in_o(sin), .modem_n_o(mdm_n));
  // ==========
  // compare and bus tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    nm_q.push_back($sformatf("reg %h", a));
    @(posedge clk);
    rd <= 1'b0;
  endtask : rreg
  task automatic tx_frame(input logic [7:0] v);
    pos = lc[1:0] + 5;
    f = {24'h0, v} & ((32'h1 << pos) - 32'h1);
    if (lc[3]) begin
      f[pos] = lc[5] ? ~lc[4] : ~(^f ^ lc[4]);
      pos++;
    end
    f[pos] = 1'b1;
    f[pos + 1] = lc[2];
    i_peer.rx_n = pos + 1 + lc[2];
    fexp_q.push_back(f);
    wreg(data_adr, v);
  endtask : tx_frame
  task automatic wait_frames();
    for (int i = 0; i < 3000 && fexp_q.size() > 0; i++) @(posedge clk);
    if (fexp_q.size() > 0) begin
      n_fail++;
      $display("BAD frame count expected 0 seen %0d", fexp_q.size());
      fexp_q.delete();
    end
    repeat (100) @(posedge clk);
  endtask : wait_frames
  task automatic test_done();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  // ==========
  // result watchers
  always @(posedge clk) begin
    if (pend) begin
      chk(nm_q.pop_front(), {24'h0, exp_q.pop_front()}, {24'h0, rdata & msk_q.pop_front()});
    end
    pend <= rd;
  end
  always @(posedge clk) begin
    if (i_peer.got.size() > 0) begin
      chk("frame", fexp_q.pop_front(), i_peer.got.pop_front());
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    test_done();
  end
  // ==========
  // main sequence
  initial begin
    void'($urandom(27700));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rreg(stat_adr, 8'h60, 8'h7F);
    lc = 8'h03;
    tx_frame(8'($urandom));
    tx_frame(8'($urandom));
    rreg(stat_adr, 8'h00, 8'h60);
    wait_frames();
    rreg(stat_adr, 8'h60, 8'h60);
    foreach (lcs[k]) begin
      lc = lcs[k];
      wreg(lctl_adr, lc);
      tx_frame(8'($urandom));
      wait_frames();
    end
    i_peer.rx_n = 9;
    fexp_q.push_back(32'h0);
    wreg(lctl_adr, 8'h43);
    repeat (1000) @(posedge clk);
    wreg(lctl_adr, 8'h3B);
    wait_frames();
    wreg(serial_channel_pkg::REG_IRQ_ENABLE, 8'h01);
    d = 8'($urandom);
    i_peer.send({22'h0, 2'b11, d}, 10);
    rreg(stat_adr, 8'h05, 8'h1F);
    rreg(data_adr, d, 8'hFF);
    rreg(stat_adr, 8'h00, 8'h1F);
    i_peer.send({22'h0, 2'b10, ~d}, 10);
    rreg(stat_adr, 8'h01, 8'h1F);
    rreg(data_adr, ~d, 8'hFF);
    wreg(lctl_adr, 8'h03);
    i_peer.send({23'h1, d}, 9);
    i_peer.send({23'h1, ~d}, 9);
    rreg(data_adr, ~d, 8'hFF);
    rreg(stat_adr, 8'h02, 8'h1F);
    rreg(stat_adr, 8'h00, 8'h1F);
    i_peer.send({24'h0, d | 8'h01}, 9);
    rreg(stat_adr, 8'h09, 8'h1F);
    rreg(data_adr, d | 8'h01, 8'hFF);
    i_peer.send(32'h0, 20);
    repeat (5) @(posedge clk);
    rreg(stat_adr, 8'h10, 8'h10);
    rreg(data_adr, 8'h00, 8'hFF);
    rreg(stat_adr, 8'h00, 8'h1C);
    // let the receiver finish the frame it restarts on the long low input
    repeat (1000) @(posedge clk);
    wreg(mctl_adr, 8'h10);
    d = 8'($urandom);
    wreg(data_adr, d);
    repeat (1000) @(posedge clk);
    rreg(data_adr, d, 8'hFF);
    wreg(mctl_adr, 8'h13);
    repeat (4) @(posedge clk);
    rreg(msta_adr, 8'h30, 8'hF0);
    wreg(mctl_adr, 8'h1C);
    repeat (4) @(posedge clk);
    rreg(msta_adr, 8'hC0, 8'hF0);
    wreg(mctl_adr, 8'h03);
    wreg(serial_channel_pkg::REG_CONFIG, 8'h01);
    repeat (4) @(posedge clk);
    rreg(msta_adr, 8'h70, 8'hF0);
    wreg(serial_channel_pkg::REG_CONFIG, 8'h00);
    i_peer.modem_n = 4'b1010;
    repeat (4) @(posedge clk);
    rreg(msta_adr, 8'h50, 8'hF0);
    i_peer.modem_n = 4'b1000;
    repeat (4) @(posedge clk);
    rreg(msta_adr, 8'h72, 8'hFF);
    rreg(msta_adr, 8'h70, 8'hFF);
    wreg(serial_channel_pkg::REG_SCRATCH, d);
    rreg(serial_channel_pkg::REG_SCRATCH, d, 8'hFF);
    rreg(4'hF, 8'h00, 8'hFF);
    wreg(serial_channel_pkg::REG_DIV_LOW, 8'h00);
    rreg(serial_channel_pkg::REG_DIV_LOW, 8'h01, 8'hFF);
    repeat (3) @(posedge clk);
    test_done();
  end
endmodule : testbench
